// ---- design/ofd_core.sv ----
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
// Function
// - Every file operand is read before writing
// - Result goes to fixed or selected place
// - Clearing a port really reads it first
// - Access bit picks access area or bank
// - Three-bit field picks bit 0 to 7
// - Destination bit: accumulator or file register
// - Eight-bit file address within selected area
// - Two-word move uses twelve-bit source, destination
// - Literals are 8 or 20 bits
// - Four table pointer update modes
// - Relative offsets signed, call targets absolute
// - Fast bit saves or restores shadow registers
// - Don't-care bits never change behaviour
// - Table access: 21-bit pointer, 8-bit latch
// - Product split into high and low byte
// - Upper program counter bytes written via latches
// - Lone second word executes as no-operation
// - Four clocks per cycle, extra cycle on jumps
module ofd_core #(
   parameter int unsigned STK_DEPTH = 4,
   parameter int unsigned TBL_AW    = 8
) (
   // Clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        rst,
   // AHB-Lite slave
   input  wire logic                        hsel,
   input  wire logic [ofd_pkg::HADDR_W-1:0] haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [ofd_pkg::DATA_W-1:0]  hwdata,
   input  wire logic                        hready,
   output logic                             hreadyout,
   output logic      [ofd_pkg::DATA_W-1:0]  hrdata,
   output logic                             hresp,
   // Port pins and change flag
   input  wire logic [ofd_pkg::BYTE_W-1:0]  port_b_pins,
   output logic                             port_change_irq_flag
);
   import ofd_pkg::*;

   localparam int unsigned SPW = $clog2(STK_DEPTH);

   typedef enum {ST_IDLE, ST_WAIT2, ST_SYNC, ST_EXEC, ST_NOP} ofd_state_e;

   ofd_state_e    st_q;
   logic [1:0]    q_q;
   logic [15:0]   w1_q, w2_q;
   logic [7:0]    work_accumulator_q, table_latch_q, product_high_byte_q, product_low_byte_q;
   logic [7:0]    pc_high_latch_q, rd_q, work_shadow_q, port_snap_q, pin_m_q, pin_s_q;
   logic [4:0]    pc_upper_latch_q;
   logic [3:0]    bank_select_reg_q, bank_shadow_q;
   logic [20:0]   table_pointer_q, pc_q;
   logic [20:0]   stk_q [STK_DEPTH];
   logic [SPW-1:0] sp_q;
   logic          pchg_q, dp_wr_q;
   logic [7:0]    dp_addr_q;
   logic [31:0]   hrdata_q;

   // Decoded fields
   ofd_op_e       op;
   ofd_tmode_e    tmode;
   logic          acc_bank, dest_file, fast;
   logic [2:0]    bit_idx;
   logic [7:0]    f8, lit8, ram_rd, tbl_rd, res;
   logic [11:0]   src12, dst12;
   logic [19:0]   lit20;
   logic [20:0]   rel_off, pc_d;

   ofd_field_split u_split (
      .first_word  (w1_q),
      .second_word (w2_q),
      .op          (op),
      .acc_bank    (acc_bank),
      .dest_file   (dest_file),
      .bit_idx     (bit_idx),
      .f8          (f8),
      .src12       (src12),
      .dst12       (dst12),
      .lit8        (lit8),
      .lit20       (lit20),
      .tmode       (tmode),
      .fast        (fast),
      .rel_off     (rel_off)
   );

   // Quarter phase of the instruction cycle
   wire rd_tick = (st_q == ST_EXEC) && (q_q == Q_READ);
   wire wr_tick = (st_q == ST_EXEC) && (q_q == Q_LAST);

   // Operation classes
   wire uses_dsel = op inside {OP_ADDWF, OP_ANDWF, OP_IORWF, OP_XORWF, OP_COMF, OP_INCF, OP_DECF,
                               OP_MOVF, OP_SWAPF};
   wire fixed_wr  = op inside {OP_CLEAR_REGISTER_OP, OP_SETF, OP_MOVWF, OP_BCF, OP_BSF, OP_BTG, OP_MOVFF};
   wire uses_file = uses_dsel || fixed_wr || (op inside {OP_MULWF, OP_BTFSC, OP_BTFSS});
   wire file_we   = fixed_wr || (uses_dsel && dest_file);
   wire work_we   = uses_dsel && !dest_file;

   // Operand address: access area ignores the bank register
   wire [11:0] banked  = acc_bank ? {bank_select_reg_q, f8}
                       : (f8 < ACCESS_SPLIT) ? {4'h0, f8} : {ACCESS_HI_BANK, f8};
   wire [11:0] rd_addr = (op == OP_MOVFF) ? src12 : banked;
   wire [11:0] wr_addr = (op == OP_MOVFF) ? dst12 : banked;

   // Special registers overlay the plain data space on reads
   wire [7:0] file_rd = (rd_addr == SFR_PORT)   ? pin_s_q
                      : (rd_addr == SFR_WORK)   ? work_accumulator_q
                      : (rd_addr == SFR_BANK)   ? {4'h0, bank_select_reg_q}
                      : (rd_addr == SFR_PRODUCT_LOW_BYTE)  ? product_low_byte_q
                      : (rd_addr == SFR_PRODUCT_HIGH_BYTE)  ? product_high_byte_q
                      : (rd_addr == SFR_TLAT)   ? table_latch_q
                      : (rd_addr == SFR_PCL)    ? pc_q[7:0]
                      : (rd_addr == SFR_PC_HIGH_LATCH) ? pc_high_latch_q
                      : (rd_addr == SFR_PC_UPPER_LATCH) ? {3'h0, pc_upper_latch_q}
                      : ram_rd;

   wire [7:0]  bit_mask = 8'h01 << bit_idx;
   wire        skip     = ((op == OP_BTFSC) && !rd_q[bit_idx]) || ((op == OP_BTFSS) && rd_q[bit_idx]);
   wire        pcl_wr   = file_we && (wr_addr == SFR_PCL);
   wire        extra    = (op inside {OP_GOTO, OP_CALL, OP_RETURN, OP_BRA, OP_MOVFF}) || skip || pcl_wr;
   wire [20:0] tbl_addr = (tmode == TM_PREINC) ? table_pointer_q + 21'd1 : table_pointer_q;
   wire [SPW-1:0] sp_top = sp_q - 1'b1;

   // Modify step; works on the value captured in the read quarter
   always_comb
   begin
      case (op)
         OP_ADDWF: res = work_accumulator_q + rd_q;
         OP_ANDWF: res = work_accumulator_q & rd_q;
         OP_IORWF: res = work_accumulator_q | rd_q;
         OP_XORWF: res = work_accumulator_q ^ rd_q;
         OP_COMF:  res = ~rd_q;
         OP_INCF:  res = rd_q + 8'h01;
         OP_DECF:  res = rd_q - 8'h01;
         OP_SWAPF: res = {rd_q[3:0], rd_q[7:4]};
         OP_CLEAR_REGISTER_OP:  res = 8'h00;
         OP_SETF:  res = 8'hff;
         OP_MOVWF: res = work_accumulator_q;
         OP_BCF:   res = rd_q & ~bit_mask;
         OP_BSF:   res = rd_q | bit_mask;
         OP_BTG:   res = rd_q ^ bit_mask;
         default:  res = rd_q;
      endcase
   end

   // Next program counter; PC counts bytes, instructions are two bytes
   always_comb
   begin
      case (op)
         OP_GOTO, OP_CALL: pc_d = {lit20, 1'b0};
         OP_RETURN:        pc_d = stk_q[sp_top];
         OP_BRA:           pc_d = pc_q + 21'd2 + {rel_off[19:0], 1'b0};
         OP_MOVFF:         pc_d = pc_q + 21'd4;
         default:          pc_d = skip ? pc_q + 21'd4 : pc_q + 21'd2;
      endcase
      if (pcl_wr)
      begin
         pc_d = {pc_upper_latch_q, pc_high_latch_q, res};
      end
   end

   ofd_byte_ram #(.AW(FADDR_W), .DW(BYTE_W)) u_data_ram (
      .clk   (core_clk),
      .we    (wr_tick && file_we),
      .waddr (wr_addr),
      .wdata (res),
      .raddr (rd_addr),
      .rdata (ram_rd)
   );

   ofd_byte_ram #(.AW(TBL_AW), .DW(BYTE_W)) u_table_ram (
      .clk   (core_clk),
      .we    (wr_tick && (op == OP_TBLWT)),
      .waddr (tbl_addr[TBL_AW-1:0]),
      .wdata (table_latch_q),
      .raddr (tbl_addr[TBL_AW-1:0]),
      .rdata (tbl_rd)
   );

   // Bus decode; register writes other than status wait while an instruction runs so core state stays coherent
   wire busy     = st_q inside {ST_SYNC, ST_EXEC, ST_NOP};
   wire a_take   = hsel && hready && htrans[1];
   wire stall    = dp_wr_q && busy && (dp_addr_q != REG_STAT);
   wire wr_go    = dp_wr_q && !stall;
   wire wr_instr = wr_go && (dp_addr_q == REG_INSTR);
   wire pchg_clr = wr_go && (dp_addr_q == REG_STAT) && hwdata[STAT_PCHG];
   wire [31:0] reg_rd = (haddr[7:0] == REG_INSTR) ? {w2_q, w1_q}
                      : (haddr[7:0] == REG_STAT)  ? {29'h0, pchg_q, st_q == ST_WAIT2, busy}
                      : (haddr[7:0] == REG_WORK)  ? {24'h0, work_accumulator_q}
                      : (haddr[7:0] == REG_BANK)  ? {28'h0, bank_select_reg_q}
                      : (haddr[7:0] == REG_TPTR)  ? {11'h0, table_pointer_q}
                      : (haddr[7:0] == REG_TLAT)  ? {24'h0, table_latch_q}
                      : (haddr[7:0] == REG_PROD)  ? {16'h0, product_high_byte_q, product_low_byte_q}
                      : (haddr[7:0] == REG_PC)    ? {11'h0, pc_q}
                      : (haddr[7:0] == REG_PCLAT) ? {19'h0, pc_upper_latch_q, pc_high_latch_q}
                      : 32'h0;

   assign hreadyout            = !stall;
   assign hresp                = 1'b0;
   assign hrdata               = hrdata_q;
   assign port_change_irq_flag = pchg_q;

   // Address phase capture; read data is ready for the data phase
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         dp_wr_q   <= 1'b0;
         dp_addr_q <= 8'h00;
         hrdata_q  <= 32'h0;
      end
      else if (hready)
      begin
         dp_wr_q   <= a_take && hwrite;
         dp_addr_q <= haddr[7:0];
         if (a_take && !hwrite)
         begin
            hrdata_q <= reg_rd;
         end
      end
   end

   // Quarter divider and pin synchroniser
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         q_q     <= 2'd0;
         pin_m_q <= BYTE_RST;
         pin_s_q <= BYTE_RST;
      end
      else
      begin
         q_q     <= q_q + 2'd1;
         pin_m_q <= port_b_pins;
         pin_s_q <= pin_m_q;
      end
   end

   // Sequencer: issue, wait for second word, align to cycle, execute, optional dead cycle
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         st_q <= ST_IDLE;
         w1_q <= 16'h0;
         w2_q <= 16'h0;
      end
      else
      begin
         case (st_q)
            ST_IDLE:
            begin
               if (wr_instr)
               begin
                  w1_q <= hwdata[15:0];
                  w2_q <= {SECOND_TAG, 12'h0};
                  st_q <= is_two_word(hwdata[15:0]) ? ST_WAIT2 : ST_SYNC;
               end
            end
            ST_WAIT2:
            begin
               if (wr_instr)
               begin
                  w2_q <= hwdata[15:0];
                  st_q <= ST_SYNC;
               end
            end
            ST_SYNC: st_q <= (q_q == Q_LAST) ? ST_EXEC : ST_SYNC;
            ST_EXEC: st_q <= wr_tick ? (extra ? ST_NOP : ST_IDLE) : ST_EXEC;
            ST_NOP:  st_q <= (q_q == Q_LAST) ? ST_IDLE : ST_NOP;
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // Read quarter: even write-only ops read, so a port read refreshes the change reference
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rd_q        <= BYTE_RST;
         port_snap_q <= BYTE_RST;
         pchg_q      <= 1'b0;
      end
      else
      begin
         if (rd_tick && uses_file)
         begin
            rd_q <= file_rd;
            if (rd_addr == SFR_PORT)
            begin
               port_snap_q <= pin_s_q;
            end
         end
         pchg_q <= (pin_s_q != port_snap_q) || (pchg_q && !pchg_clr);
      end
   end

   // Accumulator, bank and shadows
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         work_accumulator_q <= BYTE_RST;
         bank_select_reg_q  <= 4'h0;
         work_shadow_q      <= BYTE_RST;
         bank_shadow_q      <= 4'h0;
      end
      else if (wr_tick)
      begin
         if ((op == OP_RETURN) && fast)
         begin
            work_accumulator_q <= work_shadow_q;
            bank_select_reg_q  <= bank_shadow_q;
         end
         else if ((op == OP_CALL) && fast)
         begin
            work_shadow_q <= work_accumulator_q;
            bank_shadow_q <= bank_select_reg_q;
         end
         if (op == OP_MOVLW)
         begin
            work_accumulator_q <= lit8;
         end
         else if (work_we || (file_we && (wr_addr == SFR_WORK)))
         begin
            work_accumulator_q <= res;
         end
         if (op == OP_MOVLB)
         begin
            bank_select_reg_q <= lit8[3:0];
         end
         else if (file_we && (wr_addr == SFR_BANK))
         begin
            bank_select_reg_q <= res[3:0];
         end
      end
      else if (wr_go && (dp_addr_q == REG_WORK))
      begin
         work_accumulator_q <= hwdata[7:0];
      end
      else if (wr_go && (dp_addr_q == REG_BANK))
      begin
         bank_select_reg_q <= hwdata[3:0];
      end
   end

   // Table pointer, latch, product and program counter latches
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         table_pointer_q     <= PC_RST;
         table_latch_q       <= BYTE_RST;
         product_high_byte_q <= BYTE_RST;
         product_low_byte_q  <= BYTE_RST;
         pc_high_latch_q     <= BYTE_RST;
         pc_upper_latch_q    <= 5'h0;
      end
      else if (wr_tick)
      begin
         if (op inside {OP_TBLRD, OP_TBLWT})
         begin
            case (tmode)
               TM_POSTINC, TM_PREINC: table_pointer_q <= table_pointer_q + 21'd1;
               TM_POSTDEC:            table_pointer_q <= table_pointer_q - 21'd1;
               default:               table_pointer_q <= table_pointer_q;
            endcase
         end
         if (op == OP_TBLRD)
         begin
            table_latch_q <= tbl_rd;
         end
         else if (file_we && (wr_addr == SFR_TLAT))
         begin
            table_latch_q <= res;
         end
         if (op == OP_MULWF)
         begin
            {product_high_byte_q, product_low_byte_q} <= work_accumulator_q * rd_q;
         end
         if (file_we && (wr_addr == SFR_PC_HIGH_LATCH))
         begin
            pc_high_latch_q <= res;
         end
         if (file_we && (wr_addr == SFR_PC_UPPER_LATCH))
         begin
            pc_upper_latch_q <= res[4:0];
         end
      end
      else if (wr_go)
      begin
         if (dp_addr_q == REG_TPTR)
         begin
            table_pointer_q <= hwdata[20:0];
         end
         if (dp_addr_q == REG_TLAT)
         begin
            table_latch_q <= hwdata[7:0];
         end
         if (dp_addr_q == REG_PCLAT)
         begin
            {pc_upper_latch_q, pc_high_latch_q} <= hwdata[12:0];
         end
      end
   end

   // Program counter and return stack
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         pc_q <= PC_RST;
         sp_q <= '0;
      end
      else if (wr_tick)
      begin
         pc_q <= pc_d;
         if (op == OP_CALL)
         begin
            stk_q[sp_q] <= pc_q + 21'd4;
            sp_q        <= sp_q + 1'b1;
         end
         else if (op == OP_RETURN)
         begin
            sp_q <= sp_top;
         end
      end
   end

endmodule : ofd_core

// ---- design/ofd_pkg.sv ----
package ofd_pkg;

   // Bus and data widths
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned HADDR_W = 32;
   localparam int unsigned BYTE_W  = 8;
   localparam int unsigned WORD_W  = 16;
   localparam int unsigned FADDR_W = 12;
   localparam int unsigned PC_W    = 21;

   // Instruction cycle: four core clocks, read in one quarter, write back in the last
   localparam int unsigned CLK_HZ      = 20_000_000;
   localparam int unsigned Q_PER_CYCLE = 4;
   localparam logic [1:0]  Q_READ      = 2'd1;
   localparam logic [1:0]  Q_LAST      = 2'(Q_PER_CYCLE - 1);

   // Register byte offsets on the bus
   localparam logic [7:0] REG_INSTR = 8'h00;
   localparam logic [7:0] REG_STAT  = 8'h04;
   localparam logic [7:0] REG_WORK  = 8'h08;
   localparam logic [7:0] REG_BANK  = 8'h0c;
   localparam logic [7:0] REG_TPTR  = 8'h10;
   localparam logic [7:0] REG_TLAT  = 8'h14;
   localparam logic [7:0] REG_PROD  = 8'h18;
   localparam logic [7:0] REG_PC    = 8'h1c;
   localparam logic [7:0] REG_PCLAT = 8'h20;

   // Status register bit positions
   localparam int unsigned STAT_BUSY  = 0;
   localparam int unsigned STAT_WAIT2 = 1;
   localparam int unsigned STAT_PCHG  = 2;

   // Special register addresses inside the data space
   localparam logic [11:0] SFR_PORT   = 12'hfc0;
   localparam logic [11:0] SFR_WORK   = 12'hfc1;
   localparam logic [11:0] SFR_BANK   = 12'hfc2;
   localparam logic [11:0] SFR_PRODUCT_LOW_BYTE  = 12'hfc3;
   localparam logic [11:0] SFR_PRODUCT_HIGH_BYTE  = 12'hfc4;
   localparam logic [11:0] SFR_TLAT   = 12'hfc5;
   localparam logic [11:0] SFR_PCL    = 12'hfc6;
   localparam logic [11:0] SFR_PC_HIGH_LATCH = 12'hfc7;
   localparam logic [11:0] SFR_PC_UPPER_LATCH = 12'hfc8;

   // Access area: low half maps to bank 0, high half to the top bank
   localparam logic [7:0] ACCESS_SPLIT   = 8'h80;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
   localparam logic [3:0] SECOND_TAG     = 4'hf;

   // Reset values
   localparam logic [7:0]  BYTE_RST = 8'h00;
   localparam logic [20:0] PC_RST   = 21'h000000;

   typedef enum {
      OP_NOP, OP_ADDWF, OP_ANDWF, OP_IORWF, OP_XORWF, OP_COMF, OP_INCF, OP_DECF,
      OP_MOVF, OP_SWAPF, OP_CLEAR_REGISTER_OP, OP_SETF, OP_MOVWF, OP_MULWF, OP_BCF, OP_BSF,
      OP_BTG, OP_BTFSC, OP_BTFSS, OP_MOVFF, OP_MOVLW, OP_MOVLB, OP_GOTO, OP_CALL,
      OP_RETURN, OP_BRA, OP_TBLRD, OP_TBLWT
   } ofd_op_e;

   typedef enum {TM_KEEP, TM_POSTINC, TM_POSTDEC, TM_PREINC} ofd_tmode_e;

   // Opcodes that need a second word before they can run
   function automatic logic is_two_word(input logic [15:0] word);
      return (word[15:12] == 4'hc) || (word[15:9] == 7'h76) || (word[15:8] == 8'hef);
   endfunction : is_two_word

endpackage : ofd_pkg

// ---- design/ofd_byte_ram.sv ----
`timescale 1ns/1ps
module ofd_byte_ram #(
   parameter int unsigned AW = 8,
   parameter int unsigned DW = ofd_pkg::BYTE_W
) (
   // Clock
   input  wire logic          clk,
   // Write port
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   // Read port, combinational
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata
);
   import ofd_pkg::*;

   logic [DW-1:0] mem_q [2**AW];

   // Storage is not reset; contents are software defined
   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem_q[waddr] <= wdata;
      end
   end

   assign rdata = mem_q[raddr];

endmodule : ofd_byte_ram

// ---- design/ofd_field_split.sv ----
`timescale 1ns/1ps
module ofd_field_split (
   // Instruction words
   input  wire logic [ofd_pkg::WORD_W-1:0] first_word,
   input  wire logic [ofd_pkg::WORD_W-1:0] second_word,
   // Decoded operation
   output ofd_pkg::ofd_op_e                op,
   // Operand fields
   output logic                            acc_bank,
   output logic                            dest_file,
   output logic [2:0]                      bit_idx,
   output logic [7:0]                      f8,
   output logic [11:0]                     src12,
   output logic [11:0]                     dst12,
   output logic [7:0]                      lit8,
   output logic [19:0]                     lit20,
   output ofd_pkg::ofd_tmode_e             tmode,
   output logic                            fast,
   output logic [20:0]                     rel_off
);
   import ofd_pkg::*;

   // Field slices; unused bits of each format are never looked at
   assign acc_bank  = first_word[8];
   assign dest_file = first_word[9];
   assign bit_idx   = first_word[11:9];
   assign f8        = first_word[7:0];
   assign src12     = first_word[11:0];
   assign dst12     = second_word[11:0];
   assign lit8      = first_word[7:0];
   assign lit20     = {second_word[11:0], first_word[7:0]};
   assign fast      = (first_word[15:12] == 4'he) ? first_word[8] : first_word[0];
   assign rel_off   = {{10{first_word[10]}}, first_word[10:0]};

   // Table pointer mode from the two low bits
   always_comb
   begin
      case (first_word[1:0])
         2'h0: tmode = TM_KEEP;
         2'h1: tmode = TM_POSTINC;
         2'h2: tmode = TM_POSTDEC;
         default: tmode = TM_PREINC;
      endcase
   end

   // Opcode decode; don't-care positions are wildcards so their value never matters
   always_comb
   begin
      casez (first_word)
         16'b0000_0000_0001_001?: op = OP_RETURN;
         16'b0000_0000_0000_10??: op = OP_TBLRD;
         16'b0000_0000_0000_11??: op = OP_TBLWT;
         16'b0000_0000_????_????: op = OP_NOP;
         16'b0000_0001_????_????: op = OP_MOVLB;
         16'b0000_001?_????_????: op = OP_MULWF;
         16'b0000_01??_????_????: op = OP_DECF;
         16'b0000_1110_????_????: op = OP_MOVLW;
         16'b0001_00??_????_????: op = OP_IORWF;
         16'b0001_01??_????_????: op = OP_ANDWF;
         16'b0001_10??_????_????: op = OP_XORWF;
         16'b0001_11??_????_????: op = OP_COMF;
         16'b0010_01??_????_????: op = OP_ADDWF;
         16'b0010_10??_????_????: op = OP_INCF;
         16'b0011_10??_????_????: op = OP_SWAPF;
         16'b0101_00??_????_????: op = OP_MOVF;
         16'b0110_100?_????_????: op = OP_SETF;
         16'b0110_101?_????_????: op = OP_CLEAR_REGISTER_OP;
         16'b0110_111?_????_????: op = OP_MOVWF;
         16'b0111_????_????_????: op = OP_BTG;
         16'b1000_????_????_????: op = OP_BSF;
         16'b1001_????_????_????: op = OP_BCF;
         16'b1010_????_????_????: op = OP_BTFSS;
         16'b1011_????_????_????: op = OP_BTFSC;
         16'b1100_????_????_????: op = OP_MOVFF;
         16'b1101_0???_????_????: op = OP_BRA;
         16'b1110_110?_????_????: op = OP_CALL;
         16'b1110_1111_????_????: op = OP_GOTO;
         16'b1111_????_????_????: op = OP_NOP;
         default: op = OP_NOP;
      endcase
   end

endmodule : ofd_field_split

// ---- dv/ofd_core_monitor.sv ----
`timescale 1ns/1ps
module ofd_core_monitor import ofd_pkg::*; (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // Bus slave side
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic        hready,
   input  wire logic        hreadyout,
   input  wire logic [31:0] hrdata,
   input  wire logic        hresp,
   // Port change
   input  wire logic        port_change_irq_flag
);
   // Transfers taken at an edge
   wire logic take    = hsel && hready && htrans[1];
   wire logic wr_take = take && hwrite;
   wire logic rd_take = take && !hwrite;
   wire logic wr_stat = wr_take && (haddr[7:0] == REG_STAT);

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   // A write held off by a running instruction
   sequence s_wr_stall;
      wr_take ##1 !hreadyout;
   endsequence

   a_reset_idle: assert property ($fell(rst) |-> hreadyout && !port_change_irq_flag && hrdata == 32'h0)
      else $error("bus not idle after reset");
   a_stall_bounded: assert property (s_wr_stall |-> ##[1:20] hreadyout)
      else $error("write stall too long");
   a_stall_cause: assert property ($fell(hreadyout) |-> $past(wr_take))
      else $error("stall without a write");
   a_stat_no_stall: assert property (wr_stat |=> hreadyout)
      else $error("status write stalled");
   a_read_zero_wait: assert property (rd_take |=> hreadyout)
      else $error("read stalled");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("error response seen");
   a_data_stands: assert property (!$past(rd_take) |-> $stable(hrdata))
      else $error("read data moved without a read");
   // Flag only drops around a status write; a missed clear path shows here
   a_flag_sticky: assert property (port_change_irq_flag && !wr_stat && !$past(wr_stat) |=> port_change_irq_flag)
      else $error("change flag dropped by itself");
endmodule : ofd_core_monitor

bind ofd_core ofd_core_monitor u_mon (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
   .hrdata, .hresp, .port_change_irq_flag);

// ---- dv/ofd_pin_model.sv ----
`timescale 1ns/1ps
// External driver on the port pins; levels move on the clock edge itself, through a nonblocking update in step with it
module ofd_pin_model (
   // Clock
   input  wire logic       core_clk,
   // Requested level and pins
   input  wire logic [7:0] level,
   output logic      [7:0] port_b_pins
);
   initial port_b_pins = 8'h00;
   // The core synchronises the pins itself
   always @(posedge core_clk) port_b_pins <= level;
endmodule : ofd_pin_model

// ---- dv/mcu_operand_field_decoder_bench.sv ----
`timescale 1ns/1ps
module mcu_operand_field_decoder_bench;
   import ofd_pkg::*;
   `define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin bad_count++; \
      $display("mismatch %s exp %h got %h", n, e, s); end end
   logic        core_clk  = 1'b0;
   logic        rst       = 1'b1;
   logic        hsel      = 1'b0;
   logic        hwrite    = 1'b0;
   logic [1:0]  htrans    = 2'h0;
   logic [31:0] haddr     = 32'h0;
   logic [31:0] hwdata    = 32'h0;
   logic [7:0]  pin_lvl   = 8'h00;
   logic [31:0] hrdata, rd;
   logic [7:0]  pins;
   logic        hreadyout, hresp, flag;
   int          bad_count = 0;
   int          compares  = 0;
   // Instruction word, then the accumulator expected after it
   logic [23:0] steps [18] = '{24'h0e5a5a, 24'h6f105a, 24'h0e0303, 24'h6e1003, 24'h25105d, 24'h27105d,
      24'h241060, 24'h5110b7, 24'h8710b7, 24'h5110bf, 24'h7110bf, 24'h5110be, 24'hf123be, 24'h6b10be,
      24'h511000, 24'h691000, 24'h5110ff, 24'h0310ff};
   // Pointer modes: post-inc, post-dec, pre-inc, keep, from a wrapping start
   logic [15:0] tw [4] = '{16'h0009, 16'h000a, 16'h000b, 16'h0008};
   logic [20:0] tp [4] = '{21'h000000, 21'h1fffff, 21'h000000, 21'h000000};
   // Goto 0x280, fast call to 0x20, clobber the accumulator, fast return
   logic [15:0] cf [6] = '{16'hef40, 16'hf001, 16'hed10, 16'hf000, 16'h0e77, 16'h0013};

   always #25 core_clk = ~core_clk;

   ofd_core dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .port_b_pins(pins), .port_change_irq_flag(flag));
   ofd_pin_model pm (.core_clk(core_clk), .level(pin_lvl), .port_b_pins(pins));

   // One single transfer; ready is looked at before the edge that would take it
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      logic r;
      hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0, a};
      do begin @(negedge core_clk); r = hreadyout; @(posedge core_clk); end while (r !== 1'b1);
      htrans <= 2'b00; hwdata <= wd;
      do begin @(negedge core_clk); r = hreadyout; rd = hrdata; @(posedge core_clk); end while (r !== 1'b1);
   endtask : bus

   task automatic check(input string n, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(n, e, rd)
   endtask : check

   // Issue a word and wait until the status busy bit is clear again
   task automatic exec(input logic [15:0] w);
      bus(1'b1, REG_INSTR, {16'h0, w});
      do bus(1'b0, REG_STAT, 32'h0); while (rd[0] !== 1'b0);
   endtask : exec

   task automatic wrap_up();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up

   initial
   begin
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      check("unmapped", 8'h40, 32'h0);
      exec(16'h01f2);
      check("bank", REG_BANK, 32'h2);
      foreach (steps[i])
      begin
         exec(steps[i][23:8]);
         check("work", REG_WORK, {24'h0, steps[i][7:0]});
      end
      check("product", REG_PROD, 32'hfe01);
      bus(1'b1, REG_TPTR, 32'h1fffff);
      foreach (tw[i])
      begin
         exec(tw[i]);
         check("pointer", REG_TPTR, {11'h0, tp[i]});
      end
      // A register write during a running instruction waits, then lands
      bus(1'b1, REG_INSTR, 32'h0e11);
      bus(1'b1, REG_WORK, 32'h22);
      check("stalled write", REG_WORK, 32'h22);
      foreach (cf[i])
      begin
         exec(cf[i]);
      end
      check("return pc", REG_PC, 32'h284);
      check("shadow", REG_WORK, 32'h22);
      pin_lvl <= 8'h3c;
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      `CHK("flag set", 1'b1, flag)
      @(posedge core_clk);
      bus(1'b1, REG_STAT, 32'h4);
      @(negedge core_clk);
      `CHK("flag held", 1'b1, flag)
      @(posedge core_clk);
      exec(16'h6ac0);
      bus(1'b1, REG_STAT, 32'h4);
      check("status", REG_STAT, 32'h0);
      @(negedge core_clk);
      `CHK("flag cleared", 1'b0, flag)
      wrap_up();
   end

   // Whole run is well under a thousand cycles
   initial
   begin
      #(50 * 5000);
      bad_count++;
      wrap_up();
   end
endmodule : mcu_operand_field_decoder_bench
